// ### rtl/sac_adc_control.sv
// sac_adc_control: sequencing and registers of an 8-bit successive approximation converter
// assumes: analog comparator outside, answering within the same cycle; rc clock enters as a tick
`timescale 1ns/100ps
// Contract
// - channels 0-3 pins, 4/5 refs, 6/7 internal
// - result saturates at both reference ends
// - sample at start, decisions kept in approximation register
// - completion copies result, sets done flag
// - control write aborts, clears done, restarts
// - reset clears rc select and power
// - done cleared by write or result read
// - flag left set keeps converting every 32
// - rc select chooses rc clock tick
// - power off stops converter, pump, oscillator
// - powered channels 0-5 read port zero
// - register bit layout done rc power channel
// - done flag is read only
// - result holds latest valid conversion
// - wait mode keeps converting
// - stop mode halts conversion
module sac_adc_control
    import sac_pkg::*;
#(
    parameter int CONV_CYCLES = SAC_CONV_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clkEnable,
    // register port
    input wire logic [7:0] busAddr,
    input wire logic [7:0] busWriteData,
    input wire logic busWrite,
    input wire logic busRead,
    output logic [7:0] busReadData,
    // low power modes and clock source
    input wire logic stopMode,
    input wire logic waitMode,
    input wire logic rcClockTick,
    // analog side
    input wire logic comparatorAbove,
    input wire logic inputAtHighRef,
    input wire logic inputAtLowRef,
    output logic [7:0] dacCode,
    output logic sampleHold,
    output logic [2:0] channelSelect,
    output logic converterPowerOn,
    output logic chargePumpEnable,
    output logic rcOscEnable,
    // port d masking
    input wire logic [5:0] portPinsRaw,
    output logic [5:0] portPinsRead
);
    // ****************************************
    // control register and strobes
    // ****************************************
    sac_bus_t bus;
    assign bus = '{addr: busAddr, wdata: busWriteData, wr: busWrite, rd: busRead};

    logic rcClockSelect;
    logic doneFlag;
    logic [7:0] result;
    logic [7:0] approx;
    logic [7:0] trialBit;
    logic [5:0] stepCount;
    logic atHigh;
    logic atLow;
    sac_state_t state;

    logic ctrlWrite;
    logic resultRead;
    logic convTick;
    logic lastStep;
    logic running;
    logic [7:0] next_approx;

    assign ctrlWrite = bus.wr && bus.addr == SAC_OFF_STATUS_CONTROL;
    assign resultRead = bus.rd && bus.addr == SAC_OFF_RESULT;
    // wait mode does not gate the converter; only stop does
    assign running = converterPowerOn && !stopMode;
    assign convTick = rcClockSelect ? rcClockTick : 1'b1;
    assign lastStep = stepCount == 6'(CONV_CYCLES - 1);
    // when the last decision lands on the same edge as the copy, take it from next_approx
    logic [7:0] finalCode;
    assign finalCode = (trialBit != 8'h00) ? next_approx : approx;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rcClockSelect <= 1'b0;
            converterPowerOn <= 1'b0;
            channelSelect <= 3'h0;
        end else if (clkEnable && ctrlWrite) begin
            rcClockSelect <= bus.wdata[SAC_BIT_RC_SELECT];
            converterPowerOn <= bus.wdata[SAC_BIT_POWER];
            channelSelect <= bus.wdata[2:0];
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            chargePumpEnable <= 1'b0;
            rcOscEnable <= 1'b0;
        end else if (clkEnable) begin
            chargePumpEnable <= converterPowerOn && !stopMode;
            rcOscEnable <= converterPowerOn && rcClockSelect && !stopMode;
        end
    end

    // ****************************************
    // conversion sequencer
    // ****************************************
    always_comb begin
        next_approx = approx;
        if (!comparatorAbove) begin
            next_approx = approx & ~trialBit;
        end
        if (trialBit != 8'h00) begin
            next_approx = next_approx | (trialBit >> 1);
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state <= SAC_IDLE;
            stepCount <= 6'h00;
            approx <= 8'h80;
            trialBit <= 8'h80;
            sampleHold <= 1'b0;
            atHigh <= 1'b0;
            atLow <= 1'b0;
        end else if (clkEnable) begin
            if (ctrlWrite || !running) begin
                // abort: restart from the top on the new channel
                state <= SAC_IDLE;
                stepCount <= 6'h00;
                approx <= 8'h80;
                trialBit <= 8'h80;
                sampleHold <= 1'b0;
            end else begin
                unique case (state)
                    SAC_IDLE: begin
                        state <= SAC_RUN;
                        sampleHold <= 1'b1;
                        atHigh <= inputAtHighRef;
                        atLow <= inputAtLowRef;
                        stepCount <= 6'h00;
                        approx <= 8'h80;
                        trialBit <= 8'h80;
                    end
                    SAC_RUN: begin
                        if (convTick) begin
                            stepCount <= stepCount + 6'h01;
                            // one bit per step until the trial bit runs out; needs at least eight steps
                            if (trialBit != 8'h00) begin
                                approx <= next_approx;
                                trialBit <= trialBit >> 1;
                            end
                            if (lastStep) begin
                                // back to back: resample and restart with no idle cycle, period stays exact
                                stepCount <= 6'h00;
                                approx <= 8'h80;
                                trialBit <= 8'h80;
                                atHigh <= inputAtHighRef;
                                atLow <= inputAtLowRef;
                            end
                        end
                    end
                    default: state <= SAC_IDLE;
                endcase
            end
        end
    end

    // ****************************************
    // result and done flag
    // ****************************************
    logic convDone;
    assign convDone = running && !ctrlWrite && state == SAC_RUN && convTick && lastStep;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            result <= 8'h00;
        end else if (clkEnable && convDone) begin
            if (atHigh) begin
                result <= SAC_RESULT_MAX;
            end else if (atLow) begin
                result <= SAC_RESULT_MIN;
            end else begin
                result <= finalCode;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            doneFlag <= 1'b0;
        end else if (clkEnable) begin
            // completion wins over a result read in the same cycle
            if (ctrlWrite) begin
                doneFlag <= 1'b0;
            end else if (convDone) begin
                doneFlag <= 1'b1;
            end else if (resultRead) begin
                doneFlag <= 1'b0;
            end
        end
    end

    // ****************************************
    // read port and pin masking
    // ****************************************
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            busReadData <= 8'h00;
        end else if (clkEnable) begin
            if (bus.rd && bus.addr == SAC_OFF_STATUS_CONTROL) begin
                busReadData <= {doneFlag, rcClockSelect, converterPowerOn, 2'b00, channelSelect};
            end else if (resultRead) begin
                busReadData <= result;
            end else begin
                busReadData <= 8'h00;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            portPinsRead <= 6'h00;
            dacCode <= 8'h00;
        end else if (clkEnable) begin
            for (int i = 0; i < 6; i++) begin
                portPinsRead[i] <= portPinsRaw[i] && !(converterPowerOn && channelSelect == 3'(i));
            end
            dacCode <= approx;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    // cycles into the running conversion; only the period check reads it
    logic [6:0] periodCount;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            periodCount <= 7'h00;
        end else if (clkEnable) begin
            if (convDone || ctrlWrite || !running || state == SAC_IDLE) begin
                periodCount <= 7'h00;
            end else if (periodCount != 7'h7F) begin
                periodCount <= periodCount + 7'h01;
            end
        end
    end

    // ****************************************
    // checks: registers and bus
    // ****************************************
    ctrl_write_clears_a: assert property (clkEnable && ctrlWrite |=> !doneFlag)
        else $error("done not cleared");
    chan_write_a: assert property (clkEnable && ctrlWrite |=> channelSelect == $past(bus.wdata[2:0]))
        else $error("channel not stored");
    ctrl_bits_a: assert property (clkEnable && ctrlWrite
        |=> rcClockSelect == $past(bus.wdata[SAC_BIT_RC_SELECT]) && converterPowerOn == $past(bus.wdata[SAC_BIT_POWER]))
        else $error("control bits not stored");
    reserved_zero_a: assert property (clkEnable && bus.rd && bus.addr == SAC_OFF_STATUS_CONTROL
        |=> busReadData[4:3] == 2'b00)
        else $error("reserved bits nonzero");
    status_read_a: assert property (clkEnable && bus.rd && bus.addr == SAC_OFF_STATUS_CONTROL
        |=> busReadData[SAC_BIT_DONE] == $past(doneFlag))
        else $error("done bit not shown");
    result_read_a: assert property (clkEnable && resultRead |=> busReadData == $past(result))
        else $error("result not returned");
    idle_bus_a: assert property (clkEnable && !bus.rd |=> busReadData == 8'h00)
        else $error("read data without a read");
    pin_mask_a: assert property (clkEnable && converterPowerOn && channelSelect < 3'h6
        |=> portPinsRead[$past(channelSelect)] == 1'b0)
        else $error("pin not masked");
    no_mask_off_a: assert property (clkEnable && !converterPowerOn |=> portPinsRead == $past(portPinsRaw))
        else $error("pin masked while off");

    // ****************************************
    // checks: power and low power modes
    // ****************************************
    power_off_a: assert property (clkEnable && !converterPowerOn |=> !chargePumpEnable && !rcOscEnable)
        else $error("power off left pump on");
    pump_follows_a: assert property (clkEnable && converterPowerOn && !stopMode |=> chargePumpEnable)
        else $error("pump not on");
    osc_select_a: assert property (clkEnable && !rcClockSelect |=> !rcOscEnable)
        else $error("rc oscillator on unselected");
    stop_pump_a: assert property (clkEnable && stopMode |=> !chargePumpEnable && !rcOscEnable)
        else $error("pump on in stop");
    stop_halts_a: assert property (clkEnable && stopMode |=> state == SAC_IDLE && !sampleHold)
        else $error("stop did not halt");

    // ****************************************
    // checks: sequencer, result and done flag
    // ****************************************
    abort_restart_a: assert property (clkEnable && ctrlWrite |=> state == SAC_IDLE && stepCount == 6'h00)
        else $error("write did not restart");
    sample_run_a: assert property (state == SAC_RUN |-> sampleHold)
        else $error("converting without sample");
    trial_onehot_a: assert property ($onehot0(trialBit))
        else $error("trial bit not one hot");
    step_bound_a: assert property (stepCount < 6'(CONV_CYCLES))
        else $error("step count past end");
    rc_wait_a: assert property (clkEnable && running && !ctrlWrite && state == SAC_RUN
        && rcClockSelect && !rcClockTick |=> $stable(stepCount))
        else $error("step without rc tick");
    cpu_step_a: assert property (clkEnable && running && !ctrlWrite && state == SAC_RUN
        && !rcClockSelect && !lastStep |=> stepCount == $past(stepCount) + 6'h01)
        else $error("no step on processor clock");
    restart_back_a: assert property (clkEnable && convDone |=> state == SAC_RUN && stepCount == 6'h00)
        else $error("no back to back restart");
    period_a: assert property (clkEnable && convDone && !rcClockSelect
        |-> periodCount == 7'(CONV_CYCLES - 1))
        else $error("conversion period wrong");
    done_sets_a: assert property (clkEnable && convDone && !ctrlWrite |=> doneFlag)
        else $error("done not set");
    done_source_a: assert property ($rose(doneFlag) |-> $past(clkEnable && convDone))
        else $error("done set without completion");
    read_clears_a: assert property (clkEnable && resultRead && !convDone && !ctrlWrite |=> !doneFlag)
        else $error("read left done set");
    done_holds_a: assert property (clkEnable && doneFlag && !ctrlWrite && !resultRead |=> doneFlag)
        else $error("done dropped by itself");
    high_sat_a: assert property (clkEnable && convDone && atHigh |=> result == SAC_RESULT_MAX)
        else $error("no saturation high");
    low_sat_a: assert property (clkEnable && convDone && !atHigh && atLow |=> result == SAC_RESULT_MIN)
        else $error("no saturation low");
    result_hold_a: assert property (!(clkEnable && convDone) |=> $stable(result))
        else $error("result changed without completion");

    conv_done_c: cover property (convDone);
    continuous_c: cover property (convDone && doneFlag);
    abort_c: cover property (ctrlWrite && state == SAC_RUN);
    wait_conv_c: cover property (waitMode && convDone);
    rc_conv_c: cover property (rcClockSelect && convDone);
endmodule : sac_adc_control

// ### rtl/sac_pkg.sv
// sac_pkg: constants and carrier types for the converter control block
// assumes: 8-bit register port, registers at their printed byte offsets
package sac_pkg;
    localparam logic [7:0] SAC_OFF_STATUS_CONTROL = 8'h0E;
    localparam logic [7:0] SAC_OFF_RESULT = 8'h0F;
    localparam logic [7:0] SAC_STATUS_CONTROL_RESET = 8'h00;
    localparam int SAC_BIT_DONE = 7;
    localparam int SAC_BIT_RC_SELECT = 6;
    localparam int SAC_BIT_POWER = 5;
    localparam int SAC_CONV_CYCLES = 32;
    localparam logic [7:0] SAC_RESULT_MAX = 8'hFF;
    localparam logic [7:0] SAC_RESULT_MIN = 8'h00;
    localparam logic [2:0] SAC_CHAN_HIGH_REF = 3'h4;
    localparam logic [2:0] SAC_CHAN_LOW_REF = 3'h5;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sac_bus_t;

    typedef enum logic [1:0] {
        SAC_IDLE = 2'b00,
        SAC_RUN = 2'b01
    } sac_state_t;
endpackage : sac_pkg

// ### test/test_sac_adc_control.sv
// test_sac_adc_control: register-level bench for the converter control block
// assumes: sac_pkg compiled first; assertions live inside the design itself
`timescale 1ns/100ps
module test_sac_adc_control
    import sac_pkg::*;
;
    localparam int CONV = 8;
    logic clk_sys = 0;
    logic reset = 1;
    logic [7:0] busAddr = 8'h00;
    logic [7:0] busWriteData = 8'h00;
    logic busWrite = 0;
    logic busRead = 0;
    logic stopMode = 0;
    logic waitMode = 0;
    logic rcClockTick = 0;
    logic inputAtHighRef = 0;
    logic inputAtLowRef = 0;
    logic comparatorAbove = 0;
    logic [5:0] portPinsRaw = 6'h3F;
    logic [7:0] busReadData, dacCode, d;
    logic sampleHold, converterPowerOn, chargePumpEnable, rcOscEnable, rcRun = 0;
    logic [2:0] channelSelect;
    logic [5:0] portPinsRead;
    logic [1:0] tickDiv = 2'h0;
    int nFail = 0;
    int samplesChecked = 0;
    // ****************************************
    // clock, rc tick, design
    // ****************************************
    always #25 clk_sys = ~clk_sys;
    // slow tick stands in for the rc oscillator, one step every four cycles
    always @(posedge clk_sys) begin
        tickDiv <= tickDiv + 2'h1;
        rcClockTick <= rcRun & (tickDiv == 2'h3);
    end
    sac_adc_control #(.CONV_CYCLES(CONV)) sac_adc_control_inst (
        .clk_sys(clk_sys), .reset(reset), .clkEnable(1'b1),
        .busAddr(busAddr), .busWriteData(busWriteData), .busWrite(busWrite), .busRead(busRead),
        .busReadData(busReadData), .stopMode(stopMode), .waitMode(waitMode), .rcClockTick(rcClockTick),
        .comparatorAbove(comparatorAbove), .inputAtHighRef(inputAtHighRef), .inputAtLowRef(inputAtLowRef),
        .dacCode(dacCode), .sampleHold(sampleHold), .channelSelect(channelSelect),
        .converterPowerOn(converterPowerOn), .chargePumpEnable(chargePumpEnable), .rcOscEnable(rcOscEnable),
        .portPinsRaw(portPinsRaw), .portPinsRead(portPinsRead)
    );
    // ****************************************
    // bus tasks and checks
    // ****************************************
    task bus_write(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        busAddr <= a;
        busWriteData <= v;
        busWrite <= 1'b1;
        @(posedge clk_sys);
        busWrite <= 1'b0;
    endtask : bus_write
    task bus_read(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        busAddr <= a;
        busRead <= 1'b1;
        @(posedge clk_sys);
        busRead <= 1'b0;
        #1 v = busReadData;
    endtask : bus_read
    task check(input logic [7:0] got, input logic [7:0] exp, input string msg);
        samplesChecked++;
        if (got !== exp) begin
            nFail++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : check
    task read_check(input logic [7:0] a, input logic [7:0] exp, input string msg);
        bus_read(a, d);
        check(d, exp, msg);
    endtask : read_check
    task print_verdict();
        $display("counts: %0d compared, %0d wrong", samplesChecked, nFail);
        if (nFail == 0 && samplesChecked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict
    // bounded poll of the done flag; status reads leave it alone
    task wait_done(input string msg);
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < 40 && !seen; i++) begin
            bus_read(SAC_OFF_STATUS_CONTROL, d);
            seen = (d[SAC_BIT_DONE] === 1'b1);
        end
        if (!seen) begin
            nFail++;
            $display("wrong value at %0t: %s done never came", $time, msg);
            print_verdict();
        end
    endtask : wait_done
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        read_check(8'h0E, 8'h00, "status after reset");
        check({7'h00, converterPowerOn}, 8'h00, "power after reset");
        bus_write(8'h0E, 8'hFF);
        read_check(8'h0E, 8'h67, "done and unused bits not writable");
        check({3'h0, converterPowerOn, chargePumpEnable, channelSelect}, 8'h1F, "power outputs");
        check({7'h00, rcOscEnable}, 8'h01, "rc oscillator on");
        bus_write(8'h0E, 8'h00);
        read_check(8'h0E, 8'h00, "control cleared");
        check({6'h00, chargePumpEnable, rcOscEnable}, 8'h00, "power off disables pump");
        bus_write(8'h0F, 8'h55);
        read_check(8'h33, 8'h00, "unmapped read");
        $display("test registers done");
        inputAtHighRef <= 1'b1;
        bus_write(8'h0E, 8'h20);
        read_check(8'h0E, 8'h20, "done early");
        wait_done("high ref");
        read_check(8'h0F, SAC_RESULT_MAX, "high saturation");
        read_check(8'h0E, 8'h20, "result read clears done");
        wait_done("auto restart");
        inputAtHighRef <= 1'b0;
        inputAtLowRef <= 1'b1;
        repeat (3 * (CONV + 1)) @(posedge clk_sys);
        read_check(8'h0E, 8'hA0, "done stays in continuous mode");
        read_check(8'h0F, SAC_RESULT_MIN, "continuous refresh low");
        wait_done("after refresh");
        bus_write(8'h0E, 8'h21);
        read_check(8'h0E, 8'h21, "write aborts and clears done");
        wait_done("new channel");
        $display("test conversion done");
        inputAtLowRef <= 1'b0;
        comparatorAbove <= 1'b1;
        bus_write(8'h0E, 8'h22);
        wait_done("all above");
        read_check(8'h0F, 8'hFF, "every trial kept");
        comparatorAbove <= 1'b0;
        bus_write(8'h0E, 8'h22);
        wait_done("all below");
        read_check(8'h0F, 8'h00, "every trial dropped");
        inputAtHighRef <= 1'b1;
        bus_write(8'h0E, 8'h60);
        repeat (30) @(posedge clk_sys);
        read_check(8'h0E, 8'h60, "no steps without rc tick");
        rcRun <= 1'b1;
        wait_done("rc clock");
        read_check(8'h0F, SAC_RESULT_MAX, "rc result");
        rcRun <= 1'b0;
        stopMode <= 1'b1;
        bus_write(8'h0E, 8'h20);
        repeat (3 * CONV) @(posedge clk_sys);
        read_check(8'h0E, 8'h20, "stop halts");
        check({7'h00, sampleHold}, 8'h00, "no sampling in stop");
        check(dacCode, 8'h80, "trial code back at top");
        stopMode <= 1'b0;
        waitMode <= 1'b1;
        bus_write(8'h0E, 8'h20);
        wait_done("wait mode");
        check({7'h00, sampleHold}, 8'h01, "sampling in wait");
        waitMode <= 1'b0;
        $display("test modes done");
        for (int ch = 0; ch < 8; ch++) begin
            bus_write(8'h0E, 8'h20 | ch[7:0]);
            repeat (2) @(posedge clk_sys);
            check({2'b00, portPinsRead}, (ch < 6) ? 8'h3F & ~(8'h01 << ch) : 8'h3F, "port mask");
        end
        bus_write(8'h0E, 8'h03);
        repeat (2) @(posedge clk_sys);
        check({2'b00, portPinsRead}, 8'h3F, "no mask when off");
        $display("test port mask done");
        print_verdict();
    end
endmodule : test_sac_adc_control
